// ### rbs_top.sv
// Reset and brownout sequencer with core reset-state registers
// What this block does
// - Reset is entered on low external pin or brownout request.
// - During and after reset all port pins are undriven inputs.
// - Port G pins 0 and 2 pull up in reset; pin 1 is watchdog out.
// - Status, control, interrupt, timer and segment registers clear on reset.
// - Idle timer control clears except fast oscillator enable set.
// - Stack pointer resets to 06f hex.
// - Shift register keeps contents on warm reset.
// - Serial port registers clear except transmit-empty set; wakeup, converter clear.
// - Amplifier trims clear except bit 6 set; gain clears.
// - Programming address clears; timing loads 10 MHz value.
// - With watchdog, window bits go to maximum and monitor enable sets.
// - Watchdog and clock monitor are held off during reset.
// - Slow clock after reset drives pin 1 low until 16-32 ticks valid.
// - External reset during halt ends halt with full reset.
// - Below brownout, stay in reset with idle timer preset 00ff.
// - Brownout reset is released only on idle timer underflow.
// - Rising past low trigger starts 3 ms delay held in reset.
// - Countdown runs only above brownout and after delay expires.
// - Brownout above low trigger reloads timer, no power-up delay.
// - No further internal resets while supply stays above brownout.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module rbs_top
    import rbs_pkg::*;
#(
    parameter int PUP_CYCLES = RBS_PUP_CYCLES,
    parameter int IDLE_DIV = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reset_pin_n,
    input wire logic supply_above_low,
    input wire logic supply_above_bor,
    input wire logic clock_freq_ok,
    input wire logic watchdog_enable,
    input wire logic halt_req,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic chip_reset_n,
    output logic halted,
    output logic [15:0] program_counter,
    output logic [7:0] port_b_oe_n,
    output logic [7:0] port_l_oe_n,
    output logic [7:0] port_g_oe_n,
    output logic [7:0] port_g_pullup,
    output logic watchdog_output_pin_o,
    output logic watchdog_output_pin_oe_n
);
    if (PUP_CYCLES < 1 || IDLE_DIV < 1 || IDLE_DIV > 256) begin : g_bad_param
        $error("rbs_top: bad parameter");
    end
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    rbs_sync #(.W(4), .INIT(4'b0001)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d({clock_freq_ok, supply_above_bor, supply_above_low, reset_pin_n}),
        .q(pins_s)
    );
    logic pin_n_s;
    logic low_ok_s;
    logic bor_ok_s;
    logic freq_s;
    assign pin_n_s = pins_s[0];
    assign low_ok_s = pins_s[1];
    assign bor_ok_s = pins_s[2];
    assign freq_s = pins_s[3];
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    rbs_state_t state_r;
    logic [31:0] pup_cnt_r;
    logic pup_done_r;
    logic [15:0] idle_timer_r;
    logic [7:0] div_r;
    logic idle_tick;
    logic in_reset;
    logic hard_reset;
    assign idle_tick = (div_r == 8'(IDLE_DIV - 1));
    assign in_reset = (state_r != RBS_ST_RUN) || !pin_n_s;
    assign hard_reset = !resetn || !low_ok_s;
    always_ff @(posedge clk_sys) begin
        if (!resetn || idle_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 8'd1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (hard_reset) begin
            pup_cnt_r <= '0;
            pup_done_r <= 1'b0;
        end else if (!pup_done_r) begin
            if (pup_cnt_r == 32'(PUP_CYCLES - 1)) begin
                pup_done_r <= 1'b1;
            end
            pup_cnt_r <= pup_cnt_r + 32'd1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (hard_reset) begin
            state_r <= RBS_ST_BROWN;
            idle_timer_r <= RBS_IDLE_PRESET;
        end else begin
            unique case (state_r)
                RBS_ST_BROWN: begin
                    idle_timer_r <= RBS_IDLE_PRESET;
                    if (bor_ok_s) begin
                        state_r <= pup_done_r ? RBS_ST_COUNT : RBS_ST_DELAY;
                    end
                end
                RBS_ST_DELAY: begin
                    if (!bor_ok_s) begin
                        state_r <= RBS_ST_BROWN;
                    end else if (pup_done_r) begin
                        state_r <= RBS_ST_COUNT;
                    end
                end
                RBS_ST_COUNT: begin
                    if (!bor_ok_s) begin
                        state_r <= RBS_ST_BROWN;
                        idle_timer_r <= RBS_IDLE_PRESET;
                    end else if (idle_tick) begin
                        if (idle_timer_r == 16'h0000) begin
                            state_r <= RBS_ST_RUN;
                        end
                        idle_timer_r <= idle_timer_r - 16'd1;
                    end
                end
                RBS_ST_RUN: begin
                    if (!bor_ok_s) begin
                        state_r <= RBS_ST_BROWN;
                        idle_timer_r <= RBS_IDLE_PRESET;
                    end else if (idle_tick) begin
                        idle_timer_r <= idle_timer_r - 16'd1;
                    end
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // Core state held or loaded by reset
    // ------------------------------------------------------------
    logic [7:0] psw_r, main_control_reg_r, interrupt_control_reg_r, t2_r, t3_r, hst_r, seg_r;
    logic [7:0] idle_timer_control_r, sp_r, wakeup_enable_reg_r, wakeup_edge_reg_r, psr_r, enu_r, serial_port_receive_control_r;
    logic [7:0] serial_port_interrupt_control_r, converter_enable_reg_r, trimn_r, trimp_r, gain_r;
    logic [7:0] program_address_low_r, program_address_high_r, programming_timing_reg_r, serial_shift_register_r;
    logic [1:0] wdw_r;
    logic ckmon_en_r;
    logic wr;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && !in_reset;
    always_ff @(posedge clk_sys) begin
        if (!resetn || in_reset) begin
            program_counter <= RBS_PC_RST;
            {psw_r, main_control_reg_r, interrupt_control_reg_r} <= '0;
            {t2_r, t3_r, hst_r, seg_r} <= '0;
            idle_timer_control_r <= RBS_IDLE_TIMER_CONTROL_RST;
            sp_r <= RBS_SP_RST;
            {wakeup_enable_reg_r, wakeup_edge_reg_r, psr_r, converter_enable_reg_r} <= '0;
            {enu_r, serial_port_receive_control_r} <= '0;
            serial_port_interrupt_control_r <= RBS_UART_CTL_RST;
            trimn_r <= RBS_TRIM_RST;
            trimp_r <= RBS_TRIM_RST;
            gain_r <= '0;
            {program_address_low_r, program_address_high_r} <= '0;
            programming_timing_reg_r <= RBS_PROGRAMMING_TIMING_REG_10MHZ;
            wdw_r <= watchdog_enable ? RBS_WDW_MAX : 2'h0;
            ckmon_en_r <= watchdog_enable;
        end else begin
            program_counter <= program_counter + 16'd1;
            if (wr && wb_adr_i == RBS_ADR_CONTROL && wb_sel_i[0]) begin
                psw_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == RBS_ADR_CONTROL && wb_sel_i[1]) begin
                main_control_reg_r <= wb_dat_i[15:8];
            end
            if (wr && wb_adr_i == RBS_ADR_STACK && wb_sel_i[0]) begin
                sp_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == RBS_ADR_TIMER && wb_sel_i[0]) begin
                idle_timer_control_r <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == RBS_ADR_WDOG && wb_sel_i[0]) begin
                wdw_r <= wb_dat_i[1:0];
                ckmon_en_r <= wb_dat_i[2];
            end
            if (wr && wb_adr_i == RBS_ADR_PROG && wb_sel_i[0]) begin
                programming_timing_reg_r <= wb_dat_i[7:0];
            end
        end
    end
    // Shift register survives warm reset; no power-on value
    always_ff @(posedge clk_sys) begin
        if (wr && wb_adr_i == RBS_ADR_STACK && wb_sel_i[1]) begin
            serial_shift_register_r <= wb_dat_i[15:8];
        end
    end
    // ------------------------------------------------------------
    // Halt and pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn || in_reset) begin
            halted <= 1'b0;
        end else if (halt_req) begin
            halted <= 1'b1;
        end
    end
    logic ckmon_n;
    rbs_ckmon u_ckmon (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(ckmon_en_r),
        .in_reset(in_reset),
        .freq_ok(freq_s),
        .idle_tick(idle_tick),
        .err_low_n(ckmon_n)
    );
    always_ff @(posedge clk_sys) begin
        if (!resetn || in_reset) begin
            chip_reset_n <= 1'b0;
            port_b_oe_n <= 8'hff;
            port_l_oe_n <= 8'hff;
            port_g_oe_n <= 8'hff;
            port_g_pullup <= {5'h00, watchdog_enable, 2'b01}
                | 8'h04;
            watchdog_output_pin_oe_n <= 1'b1;
            watchdog_output_pin_o <= 1'b1;
        end else begin
            chip_reset_n <= 1'b1;
            port_b_oe_n <= 8'hff;
            port_l_oe_n <= 8'hff;
            port_g_oe_n <= 8'hff;
            port_g_pullup <= {5'h00, watchdog_enable, 2'b00};
            watchdog_output_pin_o <= ckmon_n;
            watchdog_output_pin_oe_n <= !(watchdog_enable && !ckmon_n);
        end
    end
    // ------------------------------------------------------------
    // Wishbone slave, one wait state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                RBS_ADR_STATUS: wb_dat_o <= {converter_enable_reg_r, gain_r, 4'h0, halted,
                    in_reset,
                    pup_done_r, bor_ok_s, low_ok_s, pin_n_s, state_r,
                    ckmon_n, 3'h0};
                RBS_ADR_CONTROL: wb_dat_o <= {interrupt_control_reg_r, seg_r, main_control_reg_r,
                    psw_r};
                RBS_ADR_STACK: wb_dat_o <= {wakeup_enable_reg_r, wakeup_edge_reg_r, serial_shift_register_r, sp_r};
                RBS_ADR_TIMER: wb_dat_o <= {idle_timer_r, psr_r, idle_timer_control_r};
                RBS_ADR_WDOG: wb_dat_o <= {hst_r, t2_r, t3_r, 5'h0,
                    ckmon_en_r, wdw_r};
                RBS_ADR_PROG: wb_dat_o <= {serial_port_interrupt_control_r, trimn_r, trimp_r,
                    programming_timing_reg_r};
                default: wb_dat_o <= '0;
            endcase
        end
    end
endmodule : rbs_top

// ### rbs_pkg.sv
// Package of constants for the reset and brownout sequencer
package rbs_pkg;
    // ------------------------------------------------------------
    // Bus register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] RBS_ADR_STATUS = 8'h00;
    localparam logic [7:0] RBS_ADR_CONTROL = 8'h04;
    localparam logic [7:0] RBS_ADR_STACK = 8'h08;
    localparam logic [7:0] RBS_ADR_TIMER = 8'h0c;
    localparam logic [7:0] RBS_ADR_WDOG = 8'h10;
    localparam logic [7:0] RBS_ADR_PROG = 8'h14;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RBS_PC_RST = 16'h0000;
    localparam logic [7:0] RBS_SP_RST = 8'h6f;
    localparam logic [7:0] RBS_IDLE_TIMER_CONTROL_RST = 8'h40;
    localparam logic [7:0] RBS_TRIM_RST = 8'h40;
    localparam logic [7:0] RBS_UART_CTL_RST = 8'h02;
    localparam int RBS_TRANSMIT_BUFFER_EMPTY_FLAG_BIT = 1;
    localparam int RBS_FAST_OSCILLATOR_ENABLE_BIT = 6;
    localparam logic [7:0] RBS_PROGRAMMING_TIMING_REG_10MHZ = 8'h31;
    localparam logic [15:0] RBS_IDLE_PRESET = 16'h00ff;
    localparam logic [1:0] RBS_WDW_MAX = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RBS_CLK_HZ = 20000000;
    localparam int RBS_PUP_DELAY_US = 3000;
    localparam int RBS_PUP_CYCLES = (RBS_CLK_HZ / 1000000) * RBS_PUP_DELAY_US;
    localparam int RBS_CKMON_MIN = 16;
    localparam int RBS_CKMON_MAX = 32;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RBS_ST_BROWN = 2'b00,
        RBS_ST_DELAY = 2'b01,
        RBS_ST_COUNT = 2'b11,
        RBS_ST_RUN = 2'b10
    } rbs_state_t;
endpackage : rbs_pkg

// ### rbs_sync.sv
// Two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module rbs_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_r <= INIT;
            q <= INIT;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule : rbs_sync

// ### rbs_ckmon.sv
// Clock monitor: holds the error output low until the clock is good
`timescale 1ns/1ps
module rbs_ckmon
    import rbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable,
    input wire logic in_reset,
    input wire logic freq_ok,
    input wire logic idle_tick,
    output logic err_low_n
);
    logic [5:0] cnt_r;
    always_ff @(posedge clk_sys) begin
        if (!resetn || in_reset || !enable) begin
            cnt_r <= '0;
            err_low_n <= 1'b1;
        end else if (!freq_ok) begin
            cnt_r <= '0;
            err_low_n <= 1'b0;
        end else if (!err_low_n && idle_tick) begin
            if (cnt_r == 6'(RBS_CKMON_MIN + 8)) begin
                err_low_n <= 1'b1;
            end
            cnt_r <= cnt_r + 6'd1;
        end
    end
endmodule : rbs_ckmon

// ### rbs_top_checker.sv
// Port checker for the reset and brownout sequencer
`timescale 1ns/1ps
module rbs_top_checker
    import rbs_pkg::*;
#(
    parameter int PUP_CYCLES = 20,
    parameter int IDLE_DIV = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reset_pin_n,
    input wire logic supply_above_bor,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic chip_reset_n,
    input wire logic halted,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] port_b_oe_n,
    input wire logic [7:0] port_l_oe_n,
    input wire logic [7:0] port_g_oe_n,
    input wire logic [7:0] port_g_pullup,
    input wire logic watchdog_output_pin_oe_n
);
    localparam int MIN_LOW = 256 * IDLE_DIV;
    logic [11:0] low_cnt_r;
    logic [3:0] quiet_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Cycles since the supply was last below brownout, and since any cause
    always_ff @(posedge clk_sys) begin
        if (!resetn || !supply_above_bor) low_cnt_r <= '0;
        else if (low_cnt_r != 12'hfff) low_cnt_r <= low_cnt_r + 12'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_pin_n || !supply_above_bor) quiet_r <= '0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
    a_pin_enters: assert property ($fell(reset_pin_n) |-> ##[1:4] !chip_reset_n)
        else $error("pin low did not reset");
    a_bor_enters: assert property ($fell(supply_above_bor) |-> ##[1:4]
        !chip_reset_n) else $error("brownout did not reset");
    a_ports_input: assert property (port_b_oe_n == 8'hff
        && port_l_oe_n == 8'hff && port_g_oe_n == 8'hff)
        else $error("port pin driven");
    a_pullup_reset: assert property (!chip_reset_n && !$past(chip_reset_n)
        |-> port_g_pullup[0] && port_g_pullup[2])
        else $error("pull-ups off in reset");
    a_pc_zero: assert property (!chip_reset_n && !$past(chip_reset_n)
        |-> program_counter == RBS_PC_RST) else $error("pc not zero");
    a_pc_runs: assert property (chip_reset_n && $past(chip_reset_n) && !halted
        && !$past(halted) |-> program_counter == $past(program_counter) + 16'h1)
        else $error("pc not counting");
    a_release_wait: assert property ($rose(chip_reset_n) |-> low_cnt_r >= MIN_LOW)
        else $error("released before countdown");
    a_no_spurious: assert property ($fell(chip_reset_n) |-> quiet_r < 4'h8)
        else $error("reset without cause");
    a_halt_exit: assert property (halted && $fell(reset_pin_n) |-> ##[1:6]
        !halted) else $error("halt not left");
    a_wdog_quiet: assert property (!chip_reset_n && !$past(chip_reset_n, 2)
        |-> watchdog_output_pin_oe_n) else $error("monitor active");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    c_release: cover property ($rose(chip_reset_n));
    c_halt_pin: cover property (halted && !reset_pin_n);
    c_mon_free: cover property ($rose(watchdog_output_pin_oe_n) && chip_reset_n);
endmodule : rbs_top_checker

bind rbs_top rbs_top_checker #(.PUP_CYCLES(PUP_CYCLES), .IDLE_DIV(IDLE_DIV))
    i_chk (.clk_sys(clk_sys), .resetn(resetn), .reset_pin_n(reset_pin_n),
    .supply_above_bor(supply_above_bor), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .chip_reset_n(chip_reset_n),
    .halted(halted), .program_counter(program_counter),
    .port_b_oe_n(port_b_oe_n), .port_l_oe_n(port_l_oe_n),
    .port_g_oe_n(port_g_oe_n), .port_g_pullup(port_g_pullup),
    .watchdog_output_pin_oe_n(watchdog_output_pin_oe_n));

// ### rbs_supply_model.sv
// Supply comparators and external reset circuit
`timescale 1ns/1ps
module rbs_supply_model (
    input wire logic clk_sys,
    input wire logic [1:0] level,
    input wire logic pin_req,
    output logic supply_above_low,
    output logic supply_above_bor,
    output logic reset_pin_n
);
    // Ten clocks make one instruction cycle; hold two more
    localparam int PULSE = 12;
    int cnt_r = 0;
    assign supply_above_low = level != 2'h0;
    assign supply_above_bor = level == 2'h2;
    always_ff @(posedge clk_sys) begin
        if (pin_req) cnt_r <= PULSE;
        else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
    assign reset_pin_n = cnt_r == 0;
endmodule : rbs_supply_model

// ### rbs_top_tb_top.sv
// Self-checking bench for the reset and brownout sequencer
`timescale 1ns/1ps
module rbs_top_tb_top;
    import rbs_pkg::*;
    localparam int PUP_T = 20;
    localparam logic [31:0] MSK [6] = '{32'hffffffff, 32'hffff00ff,
        32'hffff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] level = 2'h0;
    logic pin_req = 1'b0;
    logic clock_freq_ok = 1'b0;
    logic halt_req = 1'b0;
    logic wd_en = 1'b1;
    logic wdo;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, chip_reset_n, halted, wdo_oe_n;
    logic reset_pin_n, supply_above_low, supply_above_bor;
    logic [15:0] program_counter, seed;
    int n_errors = 0;
    int compares = 0;
    int n;
    always #25 clk_sys = ~clk_sys;
    rbs_supply_model i_sup (.clk_sys(clk_sys), .level(level), .pin_req(pin_req),
        .supply_above_low(supply_above_low), .reset_pin_n(reset_pin_n),
        .supply_above_bor(supply_above_bor));
    rbs_top #(.PUP_CYCLES(PUP_T), .IDLE_DIV(1)) i_dut (.clk_sys(clk_sys),
        .resetn(resetn), .reset_pin_n(reset_pin_n), .halt_req(halt_req),
        .supply_above_low(supply_above_low), .watchdog_enable(wd_en),
        .supply_above_bor(supply_above_bor), .clock_freq_ok(clock_freq_ok),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_reset_n(chip_reset_n),
        .halted(halted), .program_counter(program_counter), .port_b_oe_n(),
        .port_l_oe_n(), .port_g_oe_n(), .port_g_pullup(),
        .watchdog_output_pin_o(wdo), .watchdog_output_pin_oe_n(wdo_oe_n));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] exp_rv(input int k);
        case (k)
            1: return {24'h0, RBS_SP_RST};
            2: return {24'h0, RBS_IDLE_TIMER_CONTROL_RST};
            3: return {29'h0, 1'b1, RBS_WDW_MAX};
            4: return {RBS_UART_CTL_RST, RBS_TRIM_RST, RBS_TRIM_RST,
                RBS_PROGRAMMING_TIMING_REG_10MHZ};
            default: return 32'h0;
        endcase
    endfunction : exp_rv
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic wt(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : wt
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
    endtask : wb
    task automatic wait_hi(input bit wd, input int lim, output int c);
        for (c = 0; c < lim; c++) begin
            @(posedge clk_sys);
            if ((wd ? wdo_oe_n : chip_reset_n) === 1'b1) break;
        end
        if (c == lim) begin
            n_errors++;
            stop_test();
        end
    endtask : wait_hi
    initial begin
        seed = 16'h000c;
        wt(10);
        resetn <= 1'b1;
        wb(1'b1, RBS_ADR_CONTROL, 32'h0000a5a5);
        wb(1'b0, RBS_ADR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        chk({16'h0, program_counter}, {16'h0, RBS_PC_RST});
        level <= 2'h2;
        wait_hi(1'b0, 2000, n);
        chk({31'h0, n >= PUP_T + 256}, 32'h1);
        wt(2);
        chk({30'h0, wdo_oe_n, wdo}, 32'h0);
        clock_freq_ok <= 1'b1;
        wait_hi(1'b1, 100, n);
        chk({31'h0, n >= 16 && n <= 36}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            wb(1'b0, 8'h04 + 8'(k * 4) + (k == 5 ? 8'h10 : 8'h0), 32'h0);
            chk(rd & MSK[k], exp_rv(k));
        end
        $display("power up done");
        seed = lfsr(seed);
        wb(1'b1, RBS_ADR_CONTROL, {16'h0, seed});
        wb(1'b0, RBS_ADR_CONTROL, 32'h0);
        chk(rd, {16'h0, seed});
        level <= 2'h1;
        wt(8);
        chk({31'h0, chip_reset_n}, 32'h0);
        wb(1'b0, RBS_ADR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        level <= 2'h2;
        wait_hi(1'b0, 2000, n);
        chk({31'h0, n >= 256 && n < PUP_T + 256}, 32'h1);
        $display("brownout done");
        level <= 2'h0;
        wt(5);
        level <= 2'h1;
        wt(PUP_T + 20);
        chk({31'h0, chip_reset_n}, 32'h0);
        level <= 2'h2;
        wait_hi(1'b0, 2000, n);
        chk({31'h0, n >= 256 && n < PUP_T + 256}, 32'h1);
        $display("slow rise done");
        wb(1'b1, RBS_ADR_STACK, {16'h0, seed[7:0], 8'h11});
        halt_req <= 1'b1;
        wt(4);
        chk({31'h0, halted}, 32'h1);
        pin_req <= 1'b1;
        wd_en <= 1'b0;
        wt(1);
        pin_req <= 1'b0;
        wt(8);
        chk({30'h0, halted, chip_reset_n}, 32'h0);
        halt_req <= 1'b0;
        wait_hi(1'b0, 2000, n);
        wb(1'b0, RBS_ADR_STACK, 32'h0);
        chk(rd & 32'hffff, {16'h0, seed[7:0], RBS_SP_RST});
        wb(1'b0, RBS_ADR_WDOG, 32'h0);
        chk(rd, 32'h0);
        wd_en <= 1'b1;
        $display("halt done");
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            wt(seed[4:0] + 8);
            chk({31'h0, chip_reset_n}, 32'h1);
            pin_req <= seed[5];
            level <= seed[5] ? 2'h2 : 2'h1;
            wt(seed[8:6] + 2);
            pin_req <= 1'b0;
            level <= 2'h2;
            wt(6);
            chk({31'h0, chip_reset_n}, 32'h0);
            wait_hi(1'b0, 2000, n);
        end
        $display("random done");
        stop_test();
    end
endmodule : rbs_top_tb_top
